// ---- design/voltage_detect_regs.svh ----
// Register offsets, field positions and reset values of the detector control
`ifndef VOLTAGE_DETECT_REGS_SVH
`define VOLTAGE_DETECT_REGS_SVH

// Byte offsets, decoded on the low address bits
`define VD_ADDR_BITS 5
`define VD_OFS_CTRL 5'h00
`define VD_OFS_CLR 5'h04
`define VD_OFS_SET 5'h08
`define VD_OFS_INV 5'h0C
`define VD_OFS_IRQ_STATUS 5'h10
`define VD_OFS_IRQ_MASK 5'h14

// Control register fields
`define VD_BIT_ENABLE 15
`define VD_BIT_STOP_IDLE 13
`define VD_BIT_DIRECTION 11
`define VD_BIT_BANDGAP 10
`define VD_BIT_REF 9
`define VD_BIT_EVENT 8
`define VD_LIMIT_MSB 3
`define VD_LIMIT_LSB 0

// Bits that software may change in the control register
`define VD_CTRL_WMASK 32'h0000_A80F
`define VD_CTRL_RESET 32'h0000_0000

// Limit code that selects the external sense pin
`define VD_LIMIT_EXTERNAL 4'hF

// Interrupt status and mask layout
`define VD_IRQ_WIDTH 2
`define VD_IRQ_DETECT 0
`define VD_IRQ_REF_READY 1
`define VD_IRQ_RESET 2'h0

`endif

// ---- design/voltage_detect_pkg.sv ----
// Types shared by the detector control and its event core
package voltage_detect_pkg;

   // Detector sequencing states, one-hot
   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_SETTLE = 4'b0010,
      ST_ARMED = 4'b0100,
      ST_HALTED = 4'b1000
   } detect_state_type;

   typedef logic [3:0] limit_code_type;

endpackage

// ---- design/detect_core_if.sv ----
// Signals between the register side and the detector event core
`timescale 1ns/100ps

interface detect_core_if;
   logic enable;
   logic stop_in_idle;
   logic direction_select;
   voltage_detect_pkg::limit_code_type trip_limit_code;
   logic bandgap_stable_flag;
   logic ref_stable_flag;
   logic event_active_flag;
   logic trip_pulse;
   logic ref_ready_pulse;

   modport ctrl (
      output enable,
      output stop_in_idle,
      output direction_select,
      output trip_limit_code,
      input bandgap_stable_flag,
      input ref_stable_flag,
      input event_active_flag,
      input trip_pulse,
      input ref_ready_pulse
   );

   modport core (
      input enable,
      input stop_in_idle,
      input direction_select,
      input trip_limit_code,
      output bandgap_stable_flag,
      output ref_stable_flag,
      output event_active_flag,
      output trip_pulse,
      output ref_ready_pulse
   );
endinterface

// ---- design/detect_event_core.sv ----
// Detector sequencing, stability flags and trip event generation
`timescale 1ns/100ps
`include "voltage_detect_regs.svh"

module detect_event_core (
   input wire logic hclk,
   input wire logic hresetn,
   detect_core_if.core cif,
   input wire logic chip_idle,
   input wire logic bandgap_ready,
   input wire logic ref_ready,
   input wire logic sense_at_or_above,
   input wire logic sense_at_or_below,
   output logic detector_power_en,
   output logic external_sense_select,
   output voltage_detect_pkg::limit_code_type trip_select
);

   voltage_detect_pkg::detect_state_type state_reg;
   voltage_detect_pkg::detect_state_type state_next;
   logic halt;
   logic crossed;
   logic event_next;

   // (R02) idle halt
   assign halt = cif.stop_in_idle & chip_idle;

   // (R03) (R04) direction picks which comparator side counts
   assign crossed = cif.direction_select ? sense_at_or_above
                                         : sense_at_or_below;

   // Sequencing: armed only once the reference has settled
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         voltage_detect_pkg::ST_OFF: begin
            if (cif.enable && !halt)
               state_next = voltage_detect_pkg::ST_SETTLE;
         end
         voltage_detect_pkg::ST_SETTLE: begin
            if (!cif.enable)
               state_next = voltage_detect_pkg::ST_OFF;
            else if (halt)
               state_next = voltage_detect_pkg::ST_HALTED;
            else if (ref_ready)
               state_next = voltage_detect_pkg::ST_ARMED;
         end
         voltage_detect_pkg::ST_ARMED: begin
            if (!cif.enable)
               state_next = voltage_detect_pkg::ST_OFF;
            else if (halt)
               state_next = voltage_detect_pkg::ST_HALTED;
            else if (!ref_ready)
               state_next = voltage_detect_pkg::ST_SETTLE;
         end
         voltage_detect_pkg::ST_HALTED: begin
            if (!cif.enable)
               state_next = voltage_detect_pkg::ST_OFF;
            else if (!halt)
               state_next = voltage_detect_pkg::ST_SETTLE;
         end
         default: state_next = voltage_detect_pkg::ST_OFF;
      endcase
   end

   // (R01) state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         state_reg <= voltage_detect_pkg::ST_OFF;
      else
         state_reg <= state_next;
   end

   // (R16) event only while armed and enabled
   assign event_next = (state_reg == voltage_detect_pkg::ST_ARMED) &&
                       ref_ready && crossed && cif.enable && !halt;

   // (R08) event flag follows the comparator, set and cleared by hardware
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cif.event_active_flag <= 1'b0;
         cif.trip_pulse <= 1'b0;
      end else begin
         cif.event_active_flag <= event_next;
         // (R06) (R15) pulse on entry only, so a held level fires once
         cif.trip_pulse <= event_next & ~cif.event_active_flag;
      end
   end

   // (R05) (R06) stability flags mirror the analog side while powered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cif.bandgap_stable_flag <= 1'b0;
         cif.ref_stable_flag <= 1'b0;
         cif.ref_ready_pulse <= 1'b0;
      end else begin
         cif.bandgap_stable_flag <= cif.enable & bandgap_ready;
         cif.ref_stable_flag <= cif.enable & ref_ready;
         cif.ref_ready_pulse <= cif.enable & ref_ready &
                                ~cif.ref_stable_flag;
      end
   end

   // Analog controls; power drops while halted and returns once the halt ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         detector_power_en <= 1'b0;
         external_sense_select <= 1'b0;
         trip_select <= 4'h0;
      end else begin
         // (R01) power follows enable, dropped in idle halt
         detector_power_en <= cif.enable & ~halt;
         // (R09) external pin against the band gap
         external_sense_select <=
            (cif.trip_limit_code == `VD_LIMIT_EXTERNAL);
         // (R10) code passed through as the trip range
         trip_select <= cif.trip_limit_code;
      end
   end

endmodule

// ---- design/voltage_detect_control.sv ----
// Supply level detector control: AHB-Lite registers, interrupt and core
//
// Notes on behaviour
// (R01) Control bit 15 turns the detector on when one and off when zero.
// (R02) With stop-in-idle (bit 13) set the detector halts in Idle mode.
// (R03) Direction bit 11 at one raises an event at or above the trip level.
// (R04) Direction bit at zero raises an event at or below the trip level.
// (R05) Read-only bit 10 shows band gap stability, driven by hardware only.
// (R06) Bit 9 shows reference stability; no interrupt flag while it is zero.
// (R07) Software should keep the interrupt masked while bit 9 reads zero.
// (R08) Read-only bit 8 shows an active event, set and cleared by hardware.
// (R09) Limit code 1111 compares the external pin with the band gap.
// (R10) Codes 1110 to 0101 pick supply trip ranges, higher code lower volts.
// (R11) Software must not use the reserved codes 0100 to 0000.
// (R12) Bits 31-16, 14, 12 and 7-4 of the control register read zero.
// (R13) Offsets 0x4, 0x8 and 0xC clear, set or toggle the written bits.
// (R14) Status flags are read-only; writable fields reset to zero.
// (R15) A crossing in the selected direction sets the interrupt flag.
// (R16) While disabled the event flag stays zero and no interrupt is set.
`timescale 1ns/100ps
`include "voltage_detect_regs.svh"

module voltage_detect_control (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic chip_idle,
   input wire logic bandgap_ready,
   input wire logic ref_ready,
   input wire logic sense_at_or_above,
   input wire logic sense_at_or_below,
   output logic detector_power_en,
   output logic external_sense_select,
   output logic [3:0] trip_select,
   output logic irq
);

   detect_core_if cif ();

   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [`VD_IRQ_WIDTH-1:0] irq_status_reg;
   logic [`VD_IRQ_WIDTH-1:0] irq_status_next;
   logic [`VD_IRQ_WIDTH-1:0] irq_mask_reg;
   logic [`VD_IRQ_WIDTH-1:0] irq_mask_next;
   logic [`VD_IRQ_WIDTH-1:0] irq_events;
   logic wr_pend_reg;
   logic [`VD_ADDR_BITS-1:0] wr_addr_reg;
   logic rd_take;
   logic wr_take;
   logic [31:0] wmask_data;

   // Transfer in address phase: NONSEQ or SEQ while selected
   function automatic logic bus_take(input logic sel, input logic [1:0] tr,
                                     input logic rdy);
      bus_take = sel & tr[1] & rdy;
   endfunction

   // (R12) (R14) readback: writable fields plus hardware flags only
   function automatic logic [31:0] ctrl_view(input logic [31:0] c,
                                             input logic bg,
                                             input logic rf,
                                             input logic ev);
      logic [31:0] v;
      v = c & `VD_CTRL_WMASK;
      v[`VD_BIT_BANDGAP] = bg;
      v[`VD_BIT_REF] = rf;
      v[`VD_BIT_EVENT] = ev;
      ctrl_view = v;
   endfunction

   assign rd_take = bus_take(hsel, htrans, hready) & ~hwrite;
   assign wr_take = bus_take(hsel, htrans, hready) & hwrite;
   assign wmask_data = hwdata & `VD_CTRL_WMASK;

   // No wait states; every access completes OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Write address held into the data phase, where hwdata stands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= `VD_OFS_CTRL;
      end else if (hready) begin
         wr_pend_reg <= wr_take;
         wr_addr_reg <= haddr[`VD_ADDR_BITS-1:0];
      end
   end

   // (R13) control write and its clear, set and toggle aliases
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_pend_reg) begin
         case (wr_addr_reg)
            `VD_OFS_CTRL: ctrl_next = wmask_data;
            `VD_OFS_CLR: ctrl_next = ctrl_reg & ~wmask_data;
            `VD_OFS_SET: ctrl_next = ctrl_reg | wmask_data;
            `VD_OFS_INV: ctrl_next = ctrl_reg ^ wmask_data;
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   // (R14) writable fields reset to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl_reg <= `VD_CTRL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   // Fields handed to the core
   assign cif.enable = ctrl_reg[`VD_BIT_ENABLE];
   assign cif.stop_in_idle = ctrl_reg[`VD_BIT_STOP_IDLE];
   assign cif.direction_select = ctrl_reg[`VD_BIT_DIRECTION];
   assign cif.trip_limit_code = ctrl_reg[`VD_LIMIT_MSB:`VD_LIMIT_LSB];

   // (R15) (R06) trip pulse is already gated by reference stability
   assign irq_events[`VD_IRQ_DETECT] = cif.trip_pulse;
   assign irq_events[`VD_IRQ_REF_READY] = cif.ref_ready_pulse;

   // Sticky status, write one to clear; a new event wins over the clear
   always_comb begin
      irq_status_next = irq_status_reg;
      if (wr_pend_reg && wr_addr_reg == `VD_OFS_IRQ_STATUS)
         irq_status_next = irq_status_reg &
                           ~hwdata[`VD_IRQ_WIDTH-1:0];
      irq_status_next = irq_status_next | irq_events;
   end

   // Mask register write
   always_comb begin
      irq_mask_next = irq_mask_reg;
      if (wr_pend_reg && wr_addr_reg == `VD_OFS_IRQ_MASK)
         irq_mask_next = hwdata[`VD_IRQ_WIDTH-1:0];
   end

   // Interrupt status and mask registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_reg <= `VD_IRQ_RESET;
         irq_mask_reg <= `VD_IRQ_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Level interrupt, registered to keep it glitch free
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status_next & irq_mask_next);
   end

   // Read data built from next values so a read right after a write
   // sees the write; unmapped offsets read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         hrdata <= 32'h0000_0000;
         if (rd_take) begin
            case (haddr[`VD_ADDR_BITS-1:0])
               `VD_OFS_CTRL, `VD_OFS_CLR, `VD_OFS_SET, `VD_OFS_INV:
                  hrdata <= ctrl_view(ctrl_next, cif.bandgap_stable_flag,
                                      cif.ref_stable_flag,
                                      cif.event_active_flag);
               `VD_OFS_IRQ_STATUS:
                  hrdata <= {{(32-`VD_IRQ_WIDTH){1'b0}}, irq_status_next};
               `VD_OFS_IRQ_MASK:
                  hrdata <= {{(32-`VD_IRQ_WIDTH){1'b0}}, irq_mask_next};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Detector sequencing and analog controls
   detect_event_core core_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .cif(cif.core),
      .chip_idle(chip_idle),
      .bandgap_ready(bandgap_ready),
      .ref_ready(ref_ready),
      .sense_at_or_above(sense_at_or_above),
      .sense_at_or_below(sense_at_or_below),
      .detector_power_en(detector_power_en),
      .external_sense_select(external_sense_select),
      .trip_select(trip_select)
   );

endmodule

// ---- sim/supply_sense_model.sv ----
// Behavioural band gap, reference and comparator model at the analog side
`timescale 1ns/100ps

module supply_sense_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic power_en,
   input wire logic ext_sel,
   input wire logic [3:0] trip,
   input wire logic [7:0] level,
   output logic bg_ok,
   output logic ref_ok,
   output logic above,
   output logic below
);
   logic [2:0] settle;
   logic [7:0] thr;

   // Settling restarts on every power-up, so flags lag the enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn || !power_en) begin
         settle <= 3'h0;
      end else if (settle != 3'h7) begin
         settle <= settle + 3'h1;
      end
   end

   // pin against band gap, higher code lower trip
   assign thr = ext_sel ? 8'h78 : {~trip, 4'h0};
   // stability only once powered and settled
   assign bg_ok = power_en && (settle >= 3'h2);
   assign ref_ok = power_en && (settle >= 3'h4);
   assign above = power_en && (level >= thr);
   assign below = power_en && (level <= thr);
endmodule

// ---- sim/voltage_detect_control_sva.sv ----
// Concurrent checks on the detector control's ports
`timescale 1ns/100ps

module voltage_detect_control_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic chip_idle,
   input wire logic detector_power_en,
   input wire logic external_sense_select,
   input wire logic [3:0] trip_select,
   input wire logic irq
);
   logic [3:0] wr_hist;
   logic [3:0] idle_hist;
   logic [3:0] pw_hist;
   logic idle_q;

   // Four-deep cause history covers the one to two cycle output lag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_hist <= 4'h0;
         idle_hist <= 4'h0;
         pw_hist <= 4'h0;
         idle_q <= 1'b0;
      end else begin
         wr_hist <= {wr_hist[2:0], hsel & htrans[1] & hwrite & hready};
         idle_hist <= {idle_hist[2:0], chip_idle != idle_q};
         pw_hist <= {pw_hist[2:0], detector_power_en};
         idle_q <= chip_idle;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_bus_okay: assert property (
      hreadyout && !hresp) else $error("bus stalled or not okay");
   chk_reserved_zero: assert property (
      (hrdata & 32'hFFFF_50F0) == 32'h0000_0000)
      else $error("unimplemented bits read nonzero");
   chk_event_needs_ref: assert property (
      hrdata[8] |-> hrdata[9]) else $error("event without stable ref");
   chk_ext_select: assert property (
      external_sense_select == (trip_select == 4'hF))
      else $error("external select disagrees with code");
   chk_trip_by_write: assert property (
      !$stable(trip_select) |-> wr_hist != 4'h0)
      else $error("trip select moved without a write");
   chk_power_cause: assert property (
      !$stable(detector_power_en) |-> (wr_hist | idle_hist) != 4'h0)
      else $error("power changed without write or idle");
   chk_irq_clear: assert property (
      $fell(irq) |-> wr_hist != 4'h0) else $error("irq fell on its own");
   chk_irq_needs_power: assert property (
      $rose(irq) |-> (wr_hist | pw_hist) != 4'h0)
      else $error("irq rose while detector off");
endmodule

bind voltage_detect_control voltage_detect_control_sva chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .chip_idle(chip_idle),
   .detector_power_en(detector_power_en),
   .external_sense_select(external_sense_select),
   .trip_select(trip_select), .irq(irq));

// ---- sim/tb.sv ----
// Self-checking bench for the detector control over AHB-Lite
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic chip_idle = 1'b0, hreadyout, hresp, bg, rf, ab, be, pwr, ext, irq;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic [3:0] trip;
   logic [7:0] level = 8'h00;
   int failures = 0, cmp_count = 0, cycles = 0;

   always #10 hclk = ~hclk;

   voltage_detect_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .chip_idle(chip_idle),
      .bandgap_ready(bg), .ref_ready(rf), .sense_at_or_above(ab),
      .sense_at_or_below(be), .detector_power_en(pwr),
      .external_sense_select(ext), .trip_select(trip), .irq(irq));
   supply_sense_model model (.hclk(hclk), .hresetn(hresetn),
      .power_en(pwr), .ext_sel(ext), .trip(trip), .level(level),
      .bg_ok(bg), .ref_ok(rf), .above(ab), .below(be));

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict;
      end
   end

   // Single transfer: address phase held to hready, then data phase
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d); bus(1'b1, a, d); endtask
   task automatic rd(input logic [31:0] a, e);
      bus(1'b0, a, 32'h0000_0000);
      `CHK(q, e)
   endtask
   // Bounded poll of one control bit
   task automatic poll(input int b);
      int n = 0;
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      while (q[b] !== 1'b1 && n < 20) begin
         bus(1'b0, 32'h0000_0000, 32'h0000_0000);
         n++;
      end
   endtask

   task automatic t_reset;
      rd(32'h0000_0000, 32'h0000_0000);
      rd(32'h0000_0010, 32'h0000_0000);
      rd(32'h0000_0014, 32'h0000_0000);
      $display("reset values done");
   endtask

   // Halted in idle so the analog flags stay low during alias checks
   task automatic t_alias;
      chip_idle <= 1'b1;
      wr(32'h0000_0000, 32'hFFFF_FFFF);
      rd(32'h0000_0000, 32'h0000_A80F);
      wr(32'h0000_0004, 32'h0000_8001);
      rd(32'h0000_0000, 32'h0000_280E);
      wr(32'h0000_0008, 32'h0000_5011);
      rd(32'h0000_0000, 32'h0000_280F);
      wr(32'h0000_000C, 32'h0000_080F);
      rd(32'h0000_0004, 32'h0000_2000);
      rd(32'h0000_0018, 32'h0000_0000);
      wr(32'h0000_0000, 32'h0000_0000);
      chip_idle <= 1'b0;
      $display("aliases done");
   endtask

   task automatic t_codes;
      // reserved codes 4 to 0 are never programmed
      for (int k = 5; k < 16; k++) begin
         wr(32'h0000_0000, {28'h0, k[3:0]});
         rd(32'h0000_0000, {28'h0, k[3:0]});
         `CHK(trip, k[3:0])
         `CHK(ext, k == 15)
      end
      $display("limit codes done");
   endtask

   // Trip level code 8 sits at 0x70 in the model
   task automatic t_detect(input logic dir);
      logic [31:0] c;
      int n = 0;
      c = 32'h0000_8008 | {20'h0, dir, 11'h0};
      level <= dir ? 8'h40 : 8'h90;
      wr(32'h0000_0010, 32'h0000_0003);
      wr(32'h0000_0000, c);
      poll(9);
      `CHK(q[10:8], 3'b110)
      // unmask only once the reference reads stable
      wr(32'h0000_0014, 32'h0000_0001);
      level <= dir ? 8'h90 : 8'h40;
      @(negedge hclk);
      `CHK(irq, 1'b0)
      while (irq !== 1'b1 && n < 20) begin
         @(posedge hclk);
         n++;
      end
      `CHK(irq, 1'b1)
      rd(32'h0000_0000, c | 32'h0000_0700);
      rd(32'h0000_0010, 32'h0000_0003);
      wr(32'h0000_0010, 32'h0000_0003);
      @(negedge hclk);
      `CHK(irq, 1'b0)
      // mask again before the reference goes away
      wr(32'h0000_0014, 32'h0000_0000);
      wr(32'h0000_0000, 32'h0000_0000);
      rd(32'h0000_0000, 32'h0000_0000);
      $display("detect direction %0d done", dir);
   endtask

   task automatic t_idle;
      level <= 8'h40;
      chip_idle <= 1'b1;
      wr(32'h0000_0000, 32'h0000_A008);
      rd(32'h0000_0000, 32'h0000_A008);
      `CHK(pwr, 1'b0)
      wr(32'h0000_0010, 32'h0000_0003);
      @(negedge hclk);
      `CHK(irq, 1'b0)
      rd(32'h0000_0010, 32'h0000_0000);
      wr(32'h0000_0000, 32'h0000_8008);
      poll(8);
      `CHK(q[8], 1'b1)
      `CHK(pwr, 1'b1)
      // unmask with the reference stable, mask again before off
      wr(32'h0000_0014, 32'h0000_0001);
      @(negedge hclk);
      `CHK(irq, 1'b1)
      wr(32'h0000_0014, 32'h0000_0000);
      wr(32'h0000_0000, 32'h0000_0000);
      chip_idle <= 1'b0;
      wr(32'h0000_0010, 32'h0000_0003);
      $display("idle halt done");
   endtask

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_alias;
      t_codes;
      t_detect(1'b1);
      t_detect(1'b0);
      t_idle;
      wr(32'h0000_0000, 32'h0000_880F);
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      give_verdict;
   end
endmodule
